//--- rtl/rcd_pkg.sv
package rcd_pkg;

    // Field widths
    localparam int DIV_W = 3;
    localparam int DUTY_W = 2;
    localparam int CNT_W = 8;

    // Duty select codes
    localparam logic [1:0] DUTY_0 = 2'h0;
    localparam logic [1:0] DUTY_25 = 2'h1;
    localparam logic [1:0] DUTY_50 = 2'h2;
    localparam logic [1:0] DUTY_75 = 2'h3;

    // Reset values of the settings
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [1:0] DUTY_RST = 2'h0;

    // One system clock phase spans this many ref_clk cycles
    localparam logic [8:0] FOSC_HALF = 9'h001;
    // Instruction clock period in ref_clk cycles (Fosc/4)
    localparam logic [2:0] ICLK_LAST = 3'h7;
    localparam logic [2:0] ICLK_HIGH = 3'h4;

    // Software settings, grouped
    typedef struct packed {
        logic       refclk_module_enable;
        logic       refclk_pin_output_enable;
        logic       refclk_slew_limit_enable;
        logic [1:0] refclk_duty_select;
        logic [2:0] refclk_divider_select;
    } rcd_cfg_t;

endpackage

//--- rtl/rcd_top.sv
`timescale 1ns/1ps
module rcd_top
(
    input  wire logic              ref_clk,                      // Twice the system clock rate
    input  wire logic              rst,                          // Synchronous, active high
    input  wire logic              clk_en,                       // Low in sleep: state frozen
    input  wire rcd_pkg::rcd_cfg_t cfg,                          // Software settings
    input  wire logic              instruction_clock_out_enable, // Fosc/4 owns the pad
    input  wire logic              osc_pin_claimed,              // Pad serves the oscillator
    output wire logic              reference_clock_pin,          // Level driven onto the pad
    output wire logic              reference_clock_pin_oe,       // High while the pad is driven
    output wire logic              refclk_slew_limit,            // Edge-rate limit for the pad
    output wire logic              modulator_clock,              // Divided clock to modulator
    output wire logic              refclk_running                // Module enable as applied
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Period in ref_clk cycles: two per system clock, times 2**code
    function automatic logic [8:0] div_period(input logic [2:0] sel);
        div_period = 9'((rcd_pkg::FOSC_HALF << 1) << sel);
    endfunction

    // High time in ref_clk cycles for a period, duty code and divider code
    function automatic logic [8:0] high_time
    (
        input logic [8:0] per,    // Period length
        input logic [1:0] duty,   // Duty select code
        input logic [2:0] sel     // Divider code
    );
        // Zero duty holds the level low under every divider code
        if (duty == rcd_pkg::DUTY_0)
        begin
            high_time = 9'h000;
        end
        // Undivided: the source clock's own high phase passes through
        else if (sel == rcd_pkg::DIV_RST)
        begin
            high_time = rcd_pkg::FOSC_HALF;
        end
        // Divided: whole quarters of the period
        else
        begin
            case (duty)
                rcd_pkg::DUTY_25: high_time = per >> 2;
                rcd_pkg::DUTY_50: high_time = per >> 1;
                rcd_pkg::DUTY_75: high_time = 9'((per >> 1) + (per >> 2));
                default:          high_time = 9'h000;          // Not reachable
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and their next values
    logic [7:0] cnt_r;        // Position within the divided period
    logic [7:0] cnt_nxt;      // Next position within the period
    logic [2:0] icnt_r;       // Position within the Fosc/4 period
    logic [2:0] icnt_nxt;     // Next Fosc/4 position
    logic       mod_clk_r;    // Divided clock level
    logic       mod_clk_nxt;  // Level for the next count
    logic       pin_lvl_r;    // Level presented to the pad
    logic       pin_lvl_nxt;  // Pad level to register
    logic       pin_oe_r;     // Pad driver enable
    logic       pin_oe_nxt;   // Pad enable to register
    logic       slew_r;       // Applied slew limit setting
    logic       running_r;    // Applied module enable

    // Decoded settings and counter compares
    wire        en;           // Module enable bit
    wire  [8:0] per;          // Divided period in ref_clk cycles
    wire  [8:0] hi;           // High time in ref_clk cycles
    wire        wrap;         // Last count of the period
    wire        iclk;         // Fosc/4 level for this count
    wire        ref_ok;       // Reference clock may own the pad

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the settings
    assign en     = cfg.refclk_module_enable;
    assign per    = div_period(cfg.refclk_divider_select);
    assign hi     = high_time(per, cfg.refclk_duty_select,
                              cfg.refclk_divider_select);
    assign wrap   = ({1'h0, cnt_r} == 9'(per - 9'h001));
    assign iclk   = (icnt_r < rcd_pkg::ICLK_HIGH);
    // Oscillator use of the pad blocks it; the module itself still runs
    assign ref_ok = en && cfg.refclk_pin_output_enable && !osc_pin_claimed;

    ////////////////////////////////////////////////////////////////////////////
    // Next values
    // Counter advances from the system clock alone, restarts while disabled
    assign cnt_nxt     = (!en || wrap) ? 8'h00 : 8'(cnt_r + 8'h01);
    // Fosc/4 counter runs free of the module enable
    assign icnt_nxt    = (icnt_r == rcd_pkg::ICLK_LAST) ? 3'h0
                                                         : 3'(icnt_r + 3'h1);
    // Divided level is high while the next count is below the high time
    assign mod_clk_nxt = en && ({1'h0, cnt_nxt} < hi);
    // Instruction clock wins the pad over the reference clock
    assign pin_lvl_nxt = instruction_clock_out_enable ? iclk
                                                      : (ref_ok && mod_clk_nxt);
    assign pin_oe_nxt  = instruction_clock_out_enable || ref_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Period counter: clk_en low models sleep and freezes the count
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_r <= 8'h00;
        end
        else if (clk_en)
        begin
            cnt_r <= cnt_nxt;
        end
    end

    // Fosc/4 counter for the instruction clock on the pad
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            icnt_r <= 3'h0;
        end
        else if (clk_en)
        begin
            icnt_r <= icnt_nxt;
        end
    end

    // Divided level towards the modulator, whatever the pad does
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mod_clk_r <= 1'h0;
        end
        else if (clk_en)
        begin
            mod_clk_r <= mod_clk_nxt;
        end
    end

    // Pad level and driver enable, held during sleep
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_lvl_r <= 1'h0;
            pin_oe_r  <= 1'h0;
        end
        else if (clk_en)
        begin
            pin_lvl_r <= pin_lvl_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    // Applied copies of the slew and enable settings
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            slew_r    <= 1'h0;
            running_r <= 1'h0;
        end
        else if (clk_en)
        begin
            slew_r    <= cfg.refclk_slew_limit_enable;
            running_r <= en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Every output comes straight from its flip-flop
    assign reference_clock_pin    = pin_lvl_r;
    assign reference_clock_pin_oe = pin_oe_r;
    assign refclk_slew_limit      = slew_r;
    assign modulator_clock        = mod_clk_r;
    assign refclk_running         = running_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Disabled module keeps the modulator clock low
    a_disabled_low: assert property (clk_en && !en |=> !modulator_clock)
        else $error("modulator clock high while disabled");

    // Running flag follows the enable bit one edge later
    a_running_follow: assert property (
        clk_en |=> refclk_running == $past(cfg.refclk_module_enable))
        else $error("running flag does not follow enable");

    // Pad stays undriven without its enable bit
    a_pin_needs_oe: assert property (
        clk_en && !instruction_clock_out_enable && !cfg.refclk_pin_output_enable
        |=> !reference_clock_pin_oe)
        else $error("pin driven without output enable");

    // Oscillator use of the pad keeps the reference clock off it
    a_claim_blocks_pin: assert property (
        clk_en && osc_pin_claimed && !instruction_clock_out_enable
        |=> !reference_clock_pin_oe)
        else $error("pin driven while oscillator owns it");

    // Sleep freezes every output level
    a_sleep_hold: assert property (
        !clk_en |=> $stable(modulator_clock) && $stable(reference_clock_pin)
        && $stable(reference_clock_pin_oe) && $stable(refclk_slew_limit)
        && $stable(refclk_running))
        else $error("outputs moved during sleep");

    // Instruction clock owns the pad when its function is on
    a_iclk_override: assert property (
        clk_en && instruction_clock_out_enable
        |=> reference_clock_pin_oe && reference_clock_pin == $past(iclk))
        else $error("instruction clock not on pin");

    // Zero duty never raises the divided level
    a_zero_duty: assert property (
        clk_en && cfg.refclk_duty_select == rcd_pkg::DUTY_0 |=> !modulator_clock)
        else $error("zero duty produced a high level");

    // Slew output follows its bit one edge later
    a_slew_follow: assert property (
        clk_en |=> refclk_slew_limit == $past(cfg.refclk_slew_limit_enable))
        else $error("slew control not applied");

    // Divide by two at 75% goes high again right after the wrap
    a_div2_75: assert property (
        clk_en && en && cnt_r == 8'h03 && cfg.refclk_divider_select == 3'h1
        && cfg.refclk_duty_select == rcd_pkg::DUTY_75 |=> modulator_clock)
        else $error("75 percent duty start missing");

    // Undivided clock keeps the source phase
    a_div1_toggle: assert property (
        clk_en && en && cnt_r == 8'h01 && cfg.refclk_divider_select == 3'h0
        && cfg.refclk_duty_select != rcd_pkg::DUTY_0 |=> modulator_clock)
        else $error("undivided clock lost source phase");

    // Counter restarts after the last count of the period
    a_wrap_period: assert property (clk_en && en && wrap |=> cnt_r == 8'h00)
        else $error("counter did not wrap at period");

endmodule

//--- verification/rcd_ext_device.sv
`timescale 1ns/1ps
// External device clocked from the reference output pin
module rcd_ext_device
(
    input  wire logic pin_lvl,
    input  wire logic pin_oe,
    output int        edge_cnt
);
    // Pull-down keeps the pad low while nobody drives it
    wire pad   = pin_oe & pin_lvl;
    int  rises = 0;
    // Count rising edges seen on the pad
    always @(posedge pad) rises <= rises + 1;
    assign edge_cnt = rises;
endmodule

//--- verification/rcd_top_tb_top.sv
`timescale 1ns/1ps
module rcd_top_tb_top;
    logic              ref_clk = 1'h0;
    logic              rst     = 1'h1;
    logic              clk_en  = 1'h1;
    rcd_pkg::rcd_cfg_t cfg     = 8'h00;
    logic              icoe    = 1'h0;
    logic              claim   = 1'h0;
    logic              pin_o, pin_oe, slew_o, mod_o, run_o;
    int                edge_cnt, n_mod, n_pin, n_oe, n_edge;
    int                err_total = 0;
    int                compares  = 0;
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    rcd_top dut_u
    (
        .ref_clk                      (ref_clk),
        .rst                          (rst),
        .clk_en                       (clk_en),
        .cfg                          (cfg),
        .instruction_clock_out_enable (icoe),
        .osc_pin_claimed              (claim),
        .reference_clock_pin          (pin_o),
        .reference_clock_pin_oe       (pin_oe),
        .refclk_slew_limit            (slew_o),
        .modulator_clock              (mod_o),
        .refclk_running               (run_o)
    );
    rcd_ext_device ext_u
    (
        .pin_lvl  (pin_o),
        .pin_oe   (pin_oe),
        .edge_cnt (edge_cnt)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Restart from disabled with setting c, then count high levels over n cycles
    task automatic run(input logic [7:0] c, input int n);
        int e0;
        @(negedge ref_clk) cfg = 8'h00;
        @(negedge ref_clk) cfg = c;
        repeat (2) @(negedge ref_clk);
        e0 = edge_cnt;
        n_mod = 0;
        n_pin = 0;
        n_oe = 0;
        repeat (n)
        begin
            @(negedge ref_clk);
            n_mod += (mod_o === 1'h1);
            n_pin += (pin_o === 1'h1 && pin_oe === 1'h1);
            n_oe += (pin_oe === 1'h1);
        end
        n_edge = edge_cnt - e0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Every divider code at 50% duty: period 2*2^d cycles
    task automatic t_ratio();
        for (int d = 0; d < 8; d++)
        begin
            run({3'h6, 2'h2, d[2:0]}, 4 << d);
            check(n_mod, 2 << d);
            check(n_pin, 2 << d);
            check(n_edge, 2);
        end
    endtask
    // Quarter duties at divide by two
    task automatic t_half();
        run({3'h6, 2'h1, 3'h1}, 8);
        check(n_mod, 2);
        run({3'h6, 2'h3, 3'h1}, 8);
        check(n_mod, 6);
    endtask
    // Duty codes at divide by 4, and the undivided case
    task automatic t_duty();
        for (int k = 0; k < 4; k++)
        begin
            run({3'h6, k[1:0], 3'h2}, 16);
            check(n_mod, 4 * k);
        end
        run({3'h6, 2'h3, 3'h0}, 4);
        check(n_mod, 2);
        run({3'h6, 2'h0, 3'h0}, 4);
        check(n_mod, 0);
    endtask
    // Pin gating, slew bit, enable, oscillator claim, instruction clock
    task automatic t_gate();
        run({3'h5, 2'h2, 3'h1}, 8);
        check(n_oe, 0);
        check(n_mod, 4);
        check(slew_o, 1'h1);
        check(run_o, 1'h1);
        claim = 1'h1;
        run({3'h6, 2'h2, 3'h1}, 8);
        check(n_oe, 0);
        check(n_mod, 4);
        claim = 1'h0;
        run({3'h2, 2'h2, 3'h1}, 8);
        check(n_mod, 0);
        check(n_oe, 0);
        check(run_o, 1'h0);
        icoe = 1'h1;
        run({3'h6, 2'h2, 3'h3}, 16);
        check(n_pin, 8);
        check(n_oe, 16);
        icoe = 1'h0;
    endtask
    // Sleep freezes every output, then a reset clears them
    task automatic t_sleep_reset();
        logic [4:0] s;
        run({3'h7, 2'h1, 3'h2}, 3);
        clk_en = 1'h0;
        s = {pin_o, pin_oe, mod_o, run_o, slew_o};
        repeat (6) @(negedge ref_clk);
        check({pin_o, pin_oe, mod_o, run_o, slew_o}, s);
        clk_en = 1'h1;
        rst = 1'h1;
        repeat (2) @(negedge ref_clk);
        check({pin_o, pin_oe, mod_o, run_o, slew_o}, 5'h00);
        rst = 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #200000;
        err_total++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        repeat (12) @(negedge ref_clk);
        rst = 1'h0;
        t_ratio();
        t_half();
        t_duty();
        t_gate();
        t_sleep_reset();
        tally_and_finish();
    end
endmodule
